// File: pkg/sdc_map.svh
// object offsets, field positions, reset values and limits of the command objects
// assumes inclusion by bare name; definitions only
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
`define SDC_OFS_CMD_WORD 16'h6040
`define SDC_OFS_MODE_SEL 16'h6060
`define SDC_OFS_TORQUE 16'h6071
`define SDC_OFS_POSITION 16'h607a
`define SDC_OFS_VELOCITY 16'h60ff
`define SDC_RST_CMD_WORD 16'h0000
`define SDC_RST_MODE_SEL 8'h00
`define SDC_RST_TORQUE 16'h0000
`define SDC_RST_POSITION 32'h00000000
`define SDC_RST_VELOCITY 32'h00000064
`define SDC_BIT_READY 0
`define SDC_BIT_VOLTAGE 1
`define SDC_BIT_QSTOP_N 2
`define SDC_BIT_SERVO_ON 3
`define SDC_BIT_MODE_LO 4
`define SDC_BIT_RELATIVE 6
`define SDC_BIT_FAULT_RST 7
`define SDC_BIT_HALT 8
`define SDC_TORQUE_MIN 16'hec78
`define SDC_TORQUE_MAX 16'h1388
`define SDC_TORQUE_RATED 16'h03e8
`define SDC_RAMP_STEP 32'h00000064
`endif

// File: pkg/sdc_pkg.sv
// types shared by the command object block
// assumes sdc_map.svh compiled alongside
package sdc_pkg;
    typedef enum logic [7:0] {
        SDC_MODE_NONE = 8'h00,
        SDC_MODE_PP = 8'h01,
        SDC_MODE_PV = 8'h03,
        SDC_MODE_PT = 8'h04,
        SDC_MODE_HM = 8'h06,
        SDC_MODE_IP = 8'h07,
        SDC_MODE_CSP = 8'h08,
        SDC_MODE_CSV = 8'h09,
        SDC_MODE_CST = 8'h0a
    } sdc_mode_e;
    // decoded control word
    typedef struct packed {
        logic ready;
        logic voltage;
        logic quick_stop;
        logic servo_on;
        logic [2:0] mode_bits;
        logic halt;
        logic fault_reset_pulse;
    } sdc_cmd_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] data;
        logic wr;
        logic rd;
    } sdc_req_s;
endpackage

// File: rtl/sdc_cmd_decode.sv
// control word decoder: fault reset edge and command masking
// assumes the word comes from a register on the same clock
`include "sdc_map.svh"
module sdc_cmd_decode (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [15:0] word_i,
    output sdc_pkg::sdc_cmd_s cmd_o
);
    logic last_fr;
    logic next_last_fr;
    sdc_pkg::sdc_cmd_s next_cmd;
    sdc_pkg::sdc_cmd_s cmd_q;

    // decode; bits 9..15 are never looked at
    always_comb begin
        logic fr;
        fr = word_i[`SDC_BIT_FAULT_RST];
        next_last_fr = fr;
        next_cmd = '0;
        next_cmd.fault_reset_pulse = fr & ~last_fr;
        next_cmd.quick_stop = 1'b0;
        if (!fr) begin
            next_cmd.ready = word_i[`SDC_BIT_READY];
            next_cmd.voltage = word_i[`SDC_BIT_VOLTAGE];
            next_cmd.servo_on = word_i[`SDC_BIT_SERVO_ON];
            next_cmd.quick_stop = ~word_i[`SDC_BIT_QSTOP_N];
            next_cmd.mode_bits = word_i[`SDC_BIT_RELATIVE:`SDC_BIT_MODE_LO];
            next_cmd.halt = word_i[`SDC_BIT_HALT];
        end
    end

    // register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_fr <= 1'b0;
            cmd_q <= '0;
        end else if (ce_i) begin
            last_fr <= next_last_fr;
            cmd_q <= next_cmd;
        end
    end
    assign cmd_o = cmd_q;
endmodule

// File: rtl/sdc_ramp.sv
// velocity ramp toward a target with a fixed step, reports standstill
// assumes target from same clock
`include "sdc_map.svh"
module sdc_ramp #(
    parameter logic [31:0] STEP = `SDC_RAMP_STEP
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [31:0] target_i,
    output logic [31:0] value_o,
    output logic still_o
);
    logic [31:0] value;
    logic [31:0] next_value;

    // step toward target, landing exactly on it
    always_comb begin
        logic signed [32:0] diff;
        diff = $signed({target_i[31], target_i}) - $signed({value[31], value});
        next_value = value;
        if (diff > $signed({1'b0, STEP})) begin
            next_value = value + STEP;
        end else if (diff < -$signed({1'b0, STEP})) begin
            next_value = value - STEP;
        end else begin
            next_value = target_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value <= '0;
        end else if (ce_i) begin
            value <= next_value;
        end
    end
    assign value_o = value;
    assign still_o = (value == 32'h00000000);
endmodule

// File: rtl/sdc_objects.sv
// command object store: control word, mode select, setpoints, mode switch
// assumes object writes arrive synchronous to clk_i from the bus cycle logic
`include "sdc_map.svh"
module sdc_objects (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input sdc_pkg::sdc_req_s req_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    input wire logic [31:0] pos_feedback_i,
    input wire logic fault_i,
    input wire logic homing_done_i,
    input wire logic bus_sync_i,
    input wire logic [1:0] halt_option_i,
    output sdc_pkg::sdc_cmd_s cmd_o,
    output sdc_pkg::sdc_mode_e active_mode_o,
    output logic mode_switching_o,
    output logic [31:0] axis_commanded_position_monitor_o,
    output logic pos_ref_valid_o,
    output logic [31:0] vel_ref_o,
    output logic [15:0] torque_ref_o,
    output logic [1:0] halt_style_o,
    output logic fault_clear_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] drive_command_word;
    logic [7:0] operation_mode_select;
    logic [15:0] torque_setpoint;
    logic [31:0] position_setpoint;
    logic [31:0] velocity_setpoint;
    logic [15:0] next_cw;
    logic [7:0] next_ms;
    logic [15:0] next_tq;
    logic [31:0] next_pos;
    logic [31:0] next_vel;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic pos_new;
    logic next_pos_new;
    logic pos_take;

    // object writes and reads at their documented indices
    always_comb begin
        next_cw = drive_command_word;
        next_ms = operation_mode_select;
        next_tq = torque_setpoint;
        next_pos = position_setpoint;
        next_vel = velocity_setpoint;
        // a reference is consumed once, applied or discarded, so it is never replayed
        next_pos_new = pos_new & ~pos_take;
        next_rvalid = req_i.rd;
        next_rdata = 32'h00000000;
        if (req_i.wr) begin
            unique case (req_i.addr)
                `SDC_OFS_CMD_WORD: next_cw = req_i.data[15:0];
                `SDC_OFS_MODE_SEL: next_ms = req_i.data[7:0];
                `SDC_OFS_TORQUE: next_tq = req_i.data[15:0];
                `SDC_OFS_POSITION: begin
                    next_pos = req_i.data;
                    next_pos_new = 1'b1;
                end
                `SDC_OFS_VELOCITY: next_vel = req_i.data;
                default: next_cw = drive_command_word;
            endcase
        end
        if (req_i.rd) begin
            unique case (req_i.addr)
                `SDC_OFS_CMD_WORD: next_rdata = {16'h0000, drive_command_word};
                `SDC_OFS_MODE_SEL: next_rdata = {24'h000000, operation_mode_select};
                `SDC_OFS_TORQUE: next_rdata = {16'h0000, torque_setpoint};
                `SDC_OFS_POSITION: next_rdata = position_setpoint;
                `SDC_OFS_VELOCITY: next_rdata = velocity_setpoint;
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_command_word <= `SDC_RST_CMD_WORD;
            operation_mode_select <= `SDC_RST_MODE_SEL;
            torque_setpoint <= `SDC_RST_TORQUE;
            position_setpoint <= `SDC_RST_POSITION;
            velocity_setpoint <= `SDC_RST_VELOCITY;
            rdata <= 32'h00000000;
            rvalid <= 1'b0;
            pos_new <= 1'b0;
        end else if (ce_i) begin
            drive_command_word <= next_cw;
            operation_mode_select <= next_ms;
            torque_setpoint <= next_tq;
            position_setpoint <= next_pos;
            velocity_setpoint <= next_vel;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            pos_new <= next_pos_new;
        end
    end
    assign rdata_o = rdata;
    assign rvalid_o = rvalid;

    ////////////////////////////////////////////////////////////////////////
    // control word decode
    sdc_pkg::sdc_cmd_s cmd;
    sdc_cmd_decode u_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .word_i(drive_command_word),
        .cmd_o(cmd)
    );
    assign cmd_o = cmd;
    assign fault_clear_o = cmd.fault_reset_pulse;

    ////////////////////////////////////////////////////////////////////////
    // mode switch state machine
    typedef enum {ST_RUN, ST_RAMP} sdc_sw_e;
    sdc_sw_e sw;
    sdc_sw_e next_sw;
    sdc_pkg::sdc_mode_e mode;
    sdc_pkg::sdc_mode_e next_mode;
    sdc_pkg::sdc_mode_e pend;
    sdc_pkg::sdc_mode_e next_pend;
    logic homing_busy;
    logic next_homing_busy;
    logic flush;
    logic ramp_still;
    logic req_ok;
    logic vel_mode;

    // only supported assigned codes are accepted
    always_comb begin
        unique case (operation_mode_select)
            8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a: req_ok = 1'b1;
            default: req_ok = 1'b0;
        endcase
    end

    assign vel_mode = (mode == sdc_pkg::SDC_MODE_PV) || (mode == sdc_pkg::SDC_MODE_PT) ||
                      (mode == sdc_pkg::SDC_MODE_CSV) || (mode == sdc_pkg::SDC_MODE_CST);

    always_comb begin
        next_sw = sw;
        next_mode = mode;
        next_pend = pend;
        next_homing_busy = homing_busy;
        flush = 1'b0;
        if (homing_busy && (homing_done_i || fault_i || !cmd.servo_on)) begin
            next_homing_busy = 1'b0;
        end
        unique case (sw)
            ST_RUN: begin
                if (req_ok && (operation_mode_select != 8'(mode)) && !homing_busy) begin
                    next_pend = sdc_pkg::sdc_mode_e'(operation_mode_select);
                    if (mode == sdc_pkg::SDC_MODE_PP || mode == sdc_pkg::SDC_MODE_CSP) begin
                        flush = 1'b1;
                    end
                    if (vel_mode) begin
                        next_sw = ST_RAMP;
                    end else begin
                        next_mode = sdc_pkg::sdc_mode_e'(operation_mode_select);
                        next_homing_busy = (operation_mode_select == 8'h06);
                    end
                end
            end
            ST_RAMP: begin
                if (ramp_still) begin
                    next_mode = pend;
                    next_homing_busy = (pend == sdc_pkg::SDC_MODE_HM);
                    next_sw = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw <= ST_RUN;
            mode <= sdc_pkg::SDC_MODE_NONE;
            pend <= sdc_pkg::SDC_MODE_NONE;
            homing_busy <= 1'b0;
        end else if (ce_i) begin
            sw <= next_sw;
            mode <= next_mode;
            pend <= next_pend;
            homing_busy <= next_homing_busy;
        end
    end
    assign active_mode_o = mode;
    assign mode_switching_o = (sw == ST_RAMP);

    ////////////////////////////////////////////////////////////////////////
    // velocity reference with ramp; target zero while switching
    logic [31:0] ramp_target;
    assign ramp_target = (sw == ST_RAMP || (cmd.halt && halt_option_i != 2'b00)) ? 32'h00000000 :
                         ((mode == sdc_pkg::SDC_MODE_PV || mode == sdc_pkg::SDC_MODE_CSV) ?
                          velocity_setpoint : 32'h00000000);
    sdc_ramp u_ramp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .target_i(ramp_target),
        .value_o(vel_ref_o),
        .still_o(ramp_still)
    );
    assign halt_style_o = halt_option_i;

    ////////////////////////////////////////////////////////////////////////
    // position and torque references
    logic [31:0] pos_cmd;
    logic [31:0] next_pos_cmd;
    logic pos_valid;
    logic next_pos_valid;
    logic [15:0] tq_ref;
    logic [15:0] next_tq_ref;
    logic pos_mode;
    assign pos_mode = (mode == sdc_pkg::SDC_MODE_PP) || (mode == sdc_pkg::SDC_MODE_CSP);

    always_comb begin
        next_pos_cmd = pos_cmd;
        next_pos_valid = pos_valid;
        pos_take = 1'b0;
        if (flush || !pos_mode) begin
            next_pos_valid = 1'b0;
            pos_take = 1'b1; // unexecuted reference dropped
        end else if (pos_new && (bus_sync_i || mode == sdc_pkg::SDC_MODE_PP)) begin
            // cyclic target applied at the bus period edge
            pos_take = 1'b1;
            next_pos_cmd = cmd.mode_bits[2] ? pos_feedback_i + position_setpoint
                                            : position_setpoint;
            next_pos_valid = ~cmd.halt;
        end
        next_tq_ref = 16'h0000;
        if ((mode == sdc_pkg::SDC_MODE_PT || mode == sdc_pkg::SDC_MODE_CST) && sw == ST_RUN) begin
            if ($signed(torque_setpoint) > $signed(`SDC_TORQUE_MAX)) begin
                next_tq_ref = `SDC_TORQUE_MAX;
            end else if ($signed(torque_setpoint) < $signed(`SDC_TORQUE_MIN)) begin
                next_tq_ref = `SDC_TORQUE_MIN;
            end else begin
                next_tq_ref = torque_setpoint; // 0.1 percent units, 1000 rated
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_cmd <= 32'h00000000;
            pos_valid <= 1'b0;
            tq_ref <= 16'h0000;
        end else if (ce_i) begin
            pos_cmd <= next_pos_cmd;
            pos_valid <= next_pos_valid;
            tq_ref <= next_tq_ref;
        end
    end
    assign axis_commanded_position_monitor_o = pos_cmd;
    assign pos_ref_valid_o = pos_valid;
    assign torque_ref_o = tq_ref;
endmodule

// File: sim/sdc_objects_chk.sv
// assertions on the command object store ports
// assumes binding into every sdc_objects instance
`include "sdc_map.svh"
module sdc_objects_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input sdc_pkg::sdc_req_s req_i,
    input wire logic [1:0] halt_option_i,
    input sdc_pkg::sdc_cmd_s cmd_o,
    input sdc_pkg::sdc_mode_e active_mode_o,
    input wire logic mode_switching_o,
    input wire logic [31:0] vel_ref_o,
    input wire logic [15:0] torque_ref_o,
    input wire logic [1:0] halt_style_o,
    input wire logic fault_clear_o
);
    logic cw, ms, ok;
    // taken writes to the control word and mode selector, supported codes
    assign cw = ce_i && req_i.wr && req_i.addr == `SDC_OFS_CMD_WORD;
    assign ms = ce_i && req_i.wr && req_i.addr == `SDC_OFS_MODE_SEL;
    assign ok = req_i.data[7:0] inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a};
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    AST_FAULT_EDGE: assert property (fault_clear_o |->
        $past(cw, 2) && $past(req_i.data[7], 2) ##1 !fault_clear_o) else $error("stray fault clear");
    AST_FAULT_MASK: assert property (cw && req_i.data[7] |-> ##2 cmd_o[8:1] == 8'h00)
        else $error("commands not masked under fault reset");
    AST_CMD_LEVELS: assert property (cw && !req_i.data[7] |-> ##2
        {cmd_o.servo_on, cmd_o.quick_stop, cmd_o.voltage, cmd_o.ready} == ($past(req_i.data[3:0], 2) ^ 4'h4))
        else $error("command levels differ from word");
    AST_HALT_MODE_BITS: assert property (cw && !req_i.data[7] |-> ##2
        {cmd_o.halt, 1'b0, cmd_o.mode_bits} == $past(req_i.data[8:4], 2)) else $error("halt or mode bits wrong");
    AST_HALT_STYLE: assert property (halt_style_o == halt_option_i) else $error("halt style not copied");
    AST_MODE_TAKE: assert property (ms && ok && !mode_switching_o &&
        active_mode_o inside {8'h00, 8'h01, 8'h08} |-> ##2 active_mode_o == $past(req_i.data[7:0], 2))
        else $error("supported mode not entered");
    AST_MODE_KEEP: assert property (ms && !ok && !mode_switching_o |->
        ##2 active_mode_o == $past(active_mode_o, 2)) else $error("unsupported code changed the mode");
    AST_RAMP_FIRST: assert property ($changed(active_mode_o) &&
        $past(active_mode_o) inside {8'h03, 8'h04, 8'h09, 8'h0a} |-> $past(vel_ref_o) == 32'h0)
        else $error("mode left while still moving");
    AST_TORQUE_RANGE: assert property ($signed(torque_ref_o) <= $signed(`SDC_TORQUE_MAX) &&
        $signed(torque_ref_o) >= $signed(`SDC_TORQUE_MIN)) else $error("torque outside its range");
endmodule
bind sdc_objects sdc_objects_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
    .halt_option_i(halt_option_i), .cmd_o(cmd_o), .active_mode_o(active_mode_o),
    .mode_switching_o(mode_switching_o), .vel_ref_o(vel_ref_o), .torque_ref_o(torque_ref_o),
    .halt_style_o(halt_style_o), .fault_clear_o(fault_clear_o));

// File: sim/sdc_master_model.sv
// master side model: bus period strobe and servo loop position echo
// assumes the block's clock; feedback settles once per bus period
module sdc_master_model #(
    parameter int PERIOD = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] cmd_pos_i,
    output logic bus_sync_o,
    output logic [31:0] pos_feedback_o
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [31:0] next_fb;
    // one strobe a period, so cyclic position references never come closer than that
    assign bus_sync_o = cnt == 8'h00;
    always_comb begin
        next_cnt = (rst_i || cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
        next_fb = rst_i ? 32'h0 : (bus_sync_o ? cmd_pos_i : pos_feedback_o);
    end
    always_ff @(posedge clk_i) begin
        cnt <= next_cnt;
        pos_feedback_o <= next_fb;
    end
endmodule

// File: sim/tb_servo_drive_command_objects.sv
// self-checking bench for the command object store
// assumes the master model makes the bus strobe and feedback
`include "sdc_map.svh"
module tb_servo_drive_command_objects;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, ce_i, fault_i, homing_done_i, bus_sync_i, rvalid_o, mode_switching_o, fault_clear_o, prev7;
    logic pos_vld;
    logic [1:0] halt_option_i, halt_style_o;
    logic [31:0] rdata_o, pos_feedback_i, pos_mon, vel_ref_o, x, fb;
    logic [15:0] torque_ref_o, w, tq;
    logic [15:0] tab [7];
    logic [7:0] cur;
    sdc_pkg::sdc_req_s req_i;
    sdc_pkg::sdc_cmd_s cmd_o;
    sdc_pkg::sdc_mode_e active_mode_o;
    int err_total, cmp_count, seed, i, n;
    ////////////////////////////////////////
    sdc_objects uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .pos_feedback_i(pos_feedback_i), .fault_i(fault_i), .homing_done_i(homing_done_i),
        .bus_sync_i(bus_sync_i), .halt_option_i(halt_option_i), .cmd_o(cmd_o), .active_mode_o(active_mode_o),
        .mode_switching_o(mode_switching_o), .axis_commanded_position_monitor_o(pos_mon), .pos_ref_valid_o(pos_vld),
        .vel_ref_o(vel_ref_o), .torque_ref_o(torque_ref_o), .halt_style_o(halt_style_o),
        .fault_clear_o(fault_clear_o));
    sdc_master_model #(.PERIOD(20)) partner (.clk_i(clk_i), .rst_i(rst_i), .cmd_pos_i(pos_mon),
        .bus_sync_o(bus_sync_i), .pos_feedback_o(pos_feedback_i));
    ////////////////////////////////////////
    // expectations worked out from the word, the code and the limits
    function automatic logic [7:0] ecmd(input logic [15:0] v);
        return v[7] ? 8'h00 : {v[0], v[1], !v[2], v[3], v[6:4], v[8]};
    endfunction
    function automatic logic [7:0] nmode(input logic [7:0] c, input logic [7:0] p);
        return (c inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a}) ? c : p;
    endfunction
    function automatic logic [15:0] clamp(input logic [15:0] t);
        if ($signed(t) > $signed(`SDC_TORQUE_MAX)) return `SDC_TORQUE_MAX;
        if ($signed(t) < $signed(`SDC_TORQUE_MIN)) return `SDC_TORQUE_MIN;
        return t;
    endfunction
    // comparison, clocking and object access helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic acc(input logic [15:0] a, input logic [31:0] d);
        req_i = '{a, d, 1'b1, 1'b0};
        tick(1);
        req_i = '0;
        tick(1);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        req_i = '{a, 32'h0, 1'b0, 1'b1};
        tick(1);
        chk({31'h0, rvalid_o}, 32'h1, "rvalid");
        chk(rdata_o, e, "rdata");
        req_i = '0;
        tick(1);
    endtask
    task automatic setm(input logic [7:0] c);
        acc(`SDC_OFS_MODE_SEL, {24'h0, c});
        n = 0;
        while (mode_switching_o !== 1'b0 && n < 99) begin
            tick(1);
            n++;
        end
        chk({31'h0, mode_switching_o}, 32'h0, "settle");
        tick(2);
    endtask
    task automatic wsync();
        n = 0;
        while (bus_sync_i !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk({31'h0, (n < 40)}, 32'h1, "sync");
        tick(1);
    endtask
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #300000;
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        seed = 25;
        err_total = 0;
        cmp_count = 0;
        {ce_i, rst_i, fault_i, homing_done_i, prev7, halt_option_i} = 7'h60;
        req_i = '0;
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 0;
        rdchk(`SDC_OFS_CMD_WORD, 32'h0);
        rdchk(`SDC_OFS_MODE_SEL, 32'h0);
        rdchk(`SDC_OFS_TORQUE, 32'h0);
        rdchk(`SDC_OFS_POSITION, 32'h0);
        rdchk(`SDC_OFS_VELOCITY, 32'h64);
        rdchk(16'h607f, 32'h0);
        // state order patterns, held fault reset, then random words
        tab = '{16'h0006, 16'h0007, 16'h000f, 16'h0080, 16'h0080, 16'hff7b, 16'h0000};
        for (i = 0; i < 47; i++) begin
            w = (i < 7) ? tab[i] : 16'($random(seed));
            halt_option_i = 2'($random(seed));
            acc(`SDC_OFS_CMD_WORD, {16'h0, w});
            chk({24'h0, cmd_o[8:1]}, {24'h0, ecmd(w)}, "cmd");
            chk({31'h0, fault_clear_o}, {31'h0, w[7] & !prev7}, "fclr");
            chk({30'h0, halt_style_o}, {30'h0, halt_option_i}, "hstyle");
            prev7 = w[7];
            rdchk(`SDC_OFS_CMD_WORD, {16'h0, w});
        end
        // every mode code in turn, torque gated by the mode
        tq = 16'($random(seed));
        acc(`SDC_OFS_TORQUE, {16'h0, tq});
        acc(`SDC_OFS_CMD_WORD, 32'h000f);
        cur = 8'h00;
        for (i = 0; i < 12; i++) begin
            setm(8'(i));
            cur = nmode(8'(i), cur);
            chk({24'h0, active_mode_o}, {24'h0, cur}, "mode");
            chk({16'h0, torque_ref_o}, (cur inside {8'h04, 8'h0a}) ? {16'h0, clamp(tq)} : 32'h0, "tq");
            if (cur == 8'h06) begin
                setm(8'h01);
                chk({24'h0, active_mode_o}, 32'h6, "busy");
                fault_i = 1;
                tick(1);
                fault_i = 0;
                tick(2);
                cur = 8'h01;
                chk({24'h0, active_mode_o}, 32'h1, "hmfault");
            end
        end
        // torque limits at and beyond both ends
        setm(8'h04);
        tab = '{16'h1388, 16'h1389, 16'hec78, 16'hec77, 16'h8000, 16'h7fff, 16'h03e8};
        for (i = 0; i < 7; i++) begin
            acc(`SDC_OFS_TORQUE, {16'h0, tab[i]});
            tick(1);
            chk({16'h0, torque_ref_o}, {16'h0, clamp(tab[i])}, "tqlim");
        end
        // a write while the clock enable is low is not taken
        ce_i = 0;
        acc(`SDC_OFS_TORQUE, 32'h1);
        ce_i = 1;
        rdchk(`SDC_OFS_TORQUE, 32'h3e8);
        // ramp down before leaving velocity mode
        acc(`SDC_OFS_VELOCITY, 32'h1f4);
        setm(8'h03);
        tick(8);
        chk(vel_ref_o, 32'h1f4, "vel");
        acc(`SDC_OFS_MODE_SEL, 32'h1);
        chk({mode_switching_o, 23'h0, active_mode_o}, 32'h80000003, "held");
        setm(8'h01);
        chk({vel_ref_o[31:8], active_mode_o}, 32'h1, "left");
        // absolute then relative target in profile position
        x = $random(seed);
        acc(`SDC_OFS_POSITION, x);
        tick(1);
        chk(pos_mon, x, "abs");
        chk({31'h0, pos_vld}, 32'h1, "pvld");
        acc(`SDC_OFS_CMD_WORD, 32'h004f);
        wsync();
        fb = pos_feedback_i;
        acc(`SDC_OFS_POSITION, 32'h100);
        tick(1);
        chk(pos_mon, fb + 32'h100, "rel");
        // cyclic position: target waits for the bus strobe, dropped on leaving
        acc(`SDC_OFS_CMD_WORD, 32'h000f);
        setm(8'h08);
        wsync();
        x = pos_mon;
        acc(`SDC_OFS_POSITION, 32'h5555);
        chk(pos_mon, x, "hold");
        wsync();
        tick(1);
        chk(pos_mon, 32'h5555, "csp");
        wsync();
        acc(`SDC_OFS_POSITION, 32'h7777);
        setm(8'h01);
        wsync();
        wsync();
        chk(pos_mon, 32'h5555, "drop");
        chk({31'h0, pos_vld}, 32'h0, "pdrop");
        // homing holds the mode until it completes
        setm(8'h06);
        setm(8'h09);
        chk({24'h0, active_mode_o}, 32'h6, "hm");
        homing_done_i = 1;
        tick(1);
        homing_done_i = 0;
        setm(8'h09);
        chk({24'h0, active_mode_o}, 32'h9, "hmdone");
        close_out();
    end
endmodule
